// *** hdl/dmsbp_pkg.sv ***
// package for the shared-bus memory host controller
// assumes one 100 MHz clock and an APB master on the software side
package dmsbp_pkg;
   // apb register offsets (byte addresses)
   localparam logic [7:0] OFS_CTRL   = 8'h00;
   localparam logic [7:0] OFS_ADDR   = 8'h04;
   localparam logic [7:0] OFS_WDATA  = 8'h08;
   localparam logic [7:0] OFS_RDATA  = 8'h0C;
   localparam logic [7:0] OFS_STAT   = 8'h10;
   localparam logic [7:0] OFS_IRQ    = 8'h14;
   localparam logic [7:0] OFS_MASK   = 8'h18;
   localparam logic [7:0] OFS_TIMING = 8'h1C;
   // ctrl fields
   localparam int CTRL_GO     = 0;
   localparam int CTRL_WRITE  = 1;
   localparam int CTRL_TGT    = 2;
   localparam int CTRL_CESTRB = 3;
   localparam int CTRL_RST    = 4;
   // irq bits
   localparam int IRQ_DONE  = 0;
   localparam int IRQ_REJ   = 1;
   localparam int IRQ_READY = 2;
   localparam int IRQ_W     = 3;
   // address split
   localparam int SHARED_W = 17;
   localparam int UPPER_W  = 3;
   // status byte bit positions
   localparam int ST_POLL   = 7;
   localparam int ST_TOGGLE = 6;
   localparam int ST_ERROR  = 5;
   localparam int ST_TIMER  = 3;
   localparam int ST_TOG2   = 2;
   // timing: access time per cycle phase, in ns
   localparam int  T_ACCESS_NS = 100;
   localparam int  CLK_NS      = 10;
   localparam int  ACC_CYC     = (T_ACCESS_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [7:0] TIMING_RST = 8'(ACC_CYC);
   localparam logic [31:0] DATA_RST = 32'h0000_0000;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_SETUP = 3'b001,
      ST_STRB  = 3'b010,
      ST_HOLD  = 3'b011,
      ST_DONE  = 3'b100
   } dmsbp_state_e;

   // pins driven onto the shared bus
   typedef struct packed {
      logic [SHARED_W-1:0] shared_address_lines;
      logic [UPPER_W-1:0]  flash_upper_address_lines;
      logic                flash_select_n;
      logic                ram_select_low_n;
      logic                ram_select_high;
      logic                out_gate_n;
      logic                write_strobe_n;
      logic                flash_reset_n;
   } dmsbp_pins_s;
endpackage : dmsbp_pkg

// *** hdl/dmsbp_host.sv ***
// host controller driving the shared flash/static RAM bus from apb registers
// assumes bus pins are synchronous to I_CLK; data lines resolved outside
//
// Decided for this implementation: the APB interface to the registers and the register addresses.
`timescale 1ns/10ps
// Function
// - flash select may time writes while write strobe held low.
// - never select flash and static RAM at once.
// - either RAM select may time RAM writes with strobe low.
// - flash operations issued as sequences of plain write cycles.
module dmsbp_host #(
   parameter int          ACC_DEF     = dmsbp_pkg::ACC_CYC,
   parameter logic [7:0]  SUSPEND_CMD = 8'hB0
) (
   // clock and reset
   input  wire  logic        I_CLK,
   input  wire  logic        I_RST,
   // apb slave
   input  wire  logic        I_PSEL,
   input  wire  logic        I_PENABLE,
   input  wire  logic        I_PWRITE,
   input  wire  logic [7:0]  I_PADDR,
   input  wire  logic [31:0] I_PWDATA,
   output logic              O_PREADY,
   output logic              O_PSLVERR,
   output logic [31:0]       O_PRDATA,
   // memory bus
   output dmsbp_pkg::dmsbp_pins_s O_PINS,
   output logic [7:0]        O_DATA,
   output logic              O_DATA_OE_N,
   input  wire  logic [7:0]  I_DATA,
   input  wire  logic        I_FLASH_READY_BUSY,
   // interrupt
   output logic              O_IRQ
);
   logic                  wr_q, wr_d;
   logic                  tgt_q, tgt_d;
   logic                  cestrb_q, cestrb_d;
   logic                  frst_q, frst_d;
   logic [19:0]           addr_q, addr_d;
   logic [7:0]            wdat_q, wdat_d;
   logic [7:0]            rdat_q, rdat_d;
   logic [3:0]            irq_q, irq_d;
   logic [3:0]            mask_q, mask_d;
   logic [7:0]            tim_q, tim_d;
   logic [7:0]            cnt_q, cnt_d;
   logic                  rb_q;
   dmsbp_pkg::dmsbp_state_e st_q, st_d;
   dmsbp_pkg::dmsbp_pins_s  pin_q, pin_d;
   logic                  oe_n_q, oe_n_d;
   logic [31:0]           prdata_d;
   logic                  wr_acc, rd_acc, go, reject;

   function automatic logic is_off(input logic [7:0] a, input logic [7:0] o);
      return a == o;
   endfunction : is_off

   assign wr_acc    = I_PSEL & I_PENABLE & I_PWRITE;
   assign rd_acc    = I_PSEL & I_PENABLE & ~I_PWRITE;
   assign O_PREADY  = 1'b1;
   assign O_PSLVERR = 1'b0;
   assign O_PINS    = pin_q;
   assign O_DATA    = wdat_q;
   assign O_DATA_OE_N = oe_n_q;
   assign O_IRQ     = |(irq_q & mask_q);
   assign go = wr_acc & is_off(I_PADDR, dmsbp_pkg::OFS_CTRL) & I_PWDATA[dmsbp_pkg::CTRL_GO]
               & (st_q == dmsbp_pkg::ST_IDLE);
   // flash busy: only the suspend byte may be written
   assign reject = go & ~I_PWDATA[dmsbp_pkg::CTRL_TGT] & I_PWDATA[dmsbp_pkg::CTRL_WRITE]
                   & ~rb_q & (wdat_q != SUSPEND_CMD);

   always_comb begin
      wr_d = wr_q; tgt_d = tgt_q; cestrb_d = cestrb_q; frst_d = frst_q;
      addr_d = addr_q; wdat_d = wdat_q; rdat_d = rdat_q; mask_d = mask_q; tim_d = tim_q;
      irq_d = irq_q;
      if (wr_acc) begin
         if (is_off(I_PADDR, dmsbp_pkg::OFS_CTRL)) begin
            frst_d = I_PWDATA[dmsbp_pkg::CTRL_RST];
            if (go && !reject) begin
               wr_d     = I_PWDATA[dmsbp_pkg::CTRL_WRITE];
               tgt_d    = I_PWDATA[dmsbp_pkg::CTRL_TGT];
               cestrb_d = I_PWDATA[dmsbp_pkg::CTRL_CESTRB];
            end
         end
         if (is_off(I_PADDR, dmsbp_pkg::OFS_ADDR) && st_q == dmsbp_pkg::ST_IDLE)
            addr_d = I_PWDATA[19:0];
         if (is_off(I_PADDR, dmsbp_pkg::OFS_WDATA) && st_q == dmsbp_pkg::ST_IDLE)
            wdat_d = I_PWDATA[7:0];
         if (is_off(I_PADDR, dmsbp_pkg::OFS_MASK)) mask_d = I_PWDATA[3:0];
         if (is_off(I_PADDR, dmsbp_pkg::OFS_TIMING)) tim_d = (I_PWDATA[7:0] == 8'h00) ?
                                                            8'h01 : I_PWDATA[7:0];
         if (is_off(I_PADDR, dmsbp_pkg::OFS_IRQ)) irq_d = irq_q & ~I_PWDATA[3:0];
      end
      // sample read byte at end of gated access
      if (st_q == dmsbp_pkg::ST_STRB && !wr_q && cnt_q == 8'h01)
         rdat_d = I_DATA;
      // set wins over clear
      if (st_q == dmsbp_pkg::ST_DONE) irq_d[dmsbp_pkg::IRQ_DONE] = 1'b1;
      if (reject) irq_d[dmsbp_pkg::IRQ_REJ] = 1'b1;
      if (I_FLASH_READY_BUSY && !rb_q) irq_d[dmsbp_pkg::IRQ_READY] = 1'b1;
   end

   always_comb begin
      st_d = st_q; cnt_d = cnt_q;
      pin_d = pin_q; oe_n_d = oe_n_q;
      pin_d.flash_reset_n = frst_q;
      case (st_q)
         dmsbp_pkg::ST_IDLE: begin
            // both memories deselected, bus released
            pin_d.flash_select_n   = 1'b1;
            pin_d.ram_select_low_n = 1'b1;
            pin_d.ram_select_high  = 1'b0;
            pin_d.out_gate_n       = 1'b1;
            pin_d.write_strobe_n   = 1'b1;
            oe_n_d                 = 1'b1;
            if (go && !reject) begin
               st_d  = dmsbp_pkg::ST_SETUP;
               cnt_d = tim_q;
               pin_d.shared_address_lines      = addr_q[16:0];
               pin_d.flash_upper_address_lines = addr_q[19:17];
            end
         end
         dmsbp_pkg::ST_SETUP: begin
            // address set up; select-timed writes hold strobe low first
            if (wr_q) begin
               oe_n_d = 1'b0;
               if (cestrb_q) pin_d.write_strobe_n = 1'b0;
            end
            st_d = dmsbp_pkg::ST_STRB;
         end
         dmsbp_pkg::ST_STRB: begin
            // exactly one memory selected
            pin_d.flash_select_n   = tgt_q;
            pin_d.ram_select_low_n = ~tgt_q;
            pin_d.ram_select_high  = tgt_q;
            if (wr_q) pin_d.write_strobe_n = 1'b0;
            else pin_d.out_gate_n = 1'b0;
            if (!tgt_q && !frst_q) st_d = dmsbp_pkg::ST_HOLD;
            else if (cnt_q <= 8'h01) st_d = dmsbp_pkg::ST_HOLD;
            else cnt_d = cnt_q - 8'h01;
         end
         dmsbp_pkg::ST_HOLD: begin
            // deassert strobe/select while address and data still held
            pin_d.flash_select_n   = 1'b1;
            pin_d.ram_select_low_n = 1'b1;
            pin_d.ram_select_high  = 1'b0;
            pin_d.write_strobe_n   = 1'b1;
            pin_d.out_gate_n       = 1'b1;
            st_d = dmsbp_pkg::ST_DONE;
         end
         dmsbp_pkg::ST_DONE: begin
            oe_n_d = 1'b1;
            st_d   = dmsbp_pkg::ST_IDLE;
         end
         default: st_d = dmsbp_pkg::ST_IDLE;
      endcase
   end

   always_comb begin
      prdata_d = 32'h0000_0000;
      case (I_PADDR)
         dmsbp_pkg::OFS_CTRL:   prdata_d = {27'h0, frst_q, cestrb_q, tgt_q, wr_q,
                                            st_q != dmsbp_pkg::ST_IDLE};
         dmsbp_pkg::OFS_ADDR:   prdata_d = {12'h0, addr_q};
         dmsbp_pkg::OFS_WDATA:  prdata_d = {24'h0, wdat_q};
         dmsbp_pkg::OFS_RDATA:  prdata_d = {24'h0, rdat_q};
         dmsbp_pkg::OFS_STAT:   prdata_d = {22'h0, rb_q, st_q != dmsbp_pkg::ST_IDLE,
                                    rdat_q[dmsbp_pkg::ST_POLL], rdat_q[dmsbp_pkg::ST_TOGGLE],
                                    rdat_q[dmsbp_pkg::ST_ERROR], rdat_q[dmsbp_pkg::ST_TIMER],
                                    rdat_q[dmsbp_pkg::ST_TOG2], 3'h0};
         dmsbp_pkg::OFS_IRQ:    prdata_d = {28'h0, irq_q};
         dmsbp_pkg::OFS_MASK:   prdata_d = {28'h0, mask_q};
         dmsbp_pkg::OFS_TIMING: prdata_d = {24'h0, tim_q};
         default:               prdata_d = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         st_q <= dmsbp_pkg::ST_IDLE; cnt_q <= 8'h00;
         wr_q <= 1'b0; tgt_q <= 1'b0; cestrb_q <= 1'b0; frst_q <= 1'b1;
         addr_q <= 20'h00000; wdat_q <= 8'h00; rdat_q <= 8'h00;
         irq_q <= 4'h0; mask_q <= 4'h0; tim_q <= 8'(ACC_DEF);
         pin_q <= '{shared_address_lines: 17'h00000, flash_upper_address_lines: 3'h0,
                    flash_select_n: 1'b1, ram_select_low_n: 1'b1, ram_select_high: 1'b0,
                    out_gate_n: 1'b1, write_strobe_n: 1'b1, flash_reset_n: 1'b1};
         oe_n_q <= 1'b1; rb_q <= 1'b1; O_PRDATA <= dmsbp_pkg::DATA_RST;
      end else begin
         st_q <= st_d; cnt_q <= cnt_d;
         wr_q <= wr_d; tgt_q <= tgt_d; cestrb_q <= cestrb_d; frst_q <= frst_d;
         addr_q <= addr_d; wdat_q <= wdat_d; rdat_q <= rdat_d;
         irq_q <= irq_d; mask_q <= mask_d; tim_q <= tim_d;
         pin_q <= pin_d; oe_n_q <= oe_n_d; rb_q <= I_FLASH_READY_BUSY;
         if (I_PSEL && !I_PENABLE) O_PRDATA <= prdata_d;
      end
   end

   a_no_dual_select: assert property (@(posedge I_CLK) disable iff (I_RST)
      !(!pin_q.flash_select_n && !pin_q.ram_select_low_n && pin_q.ram_select_high))
      else $error("flash and ram selected together");
   a_gate_vs_drive: assert property (@(posedge I_CLK) disable iff (I_RST)
      !(!pin_q.out_gate_n && !oe_n_q)) else $error("gate low while host drives data");
   a_gate_no_strobe: assert property (@(posedge I_CLK) disable iff (I_RST)
      !pin_q.out_gate_n |-> pin_q.write_strobe_n) else $error("read with strobe low");
   a_data_held: assert property (@(posedge I_CLK) disable iff (I_RST)
      (!pin_q.write_strobe_n && $rose(pin_q.write_strobe_n) == 1'b0) ##1
      pin_q.write_strobe_n |-> !oe_n_q) else $error("data released before strobe rise");
   a_addr_stable: assert property (@(posedge I_CLK) disable iff (I_RST)
      st_q != dmsbp_pkg::ST_IDLE && $past(st_q) != dmsbp_pkg::ST_IDLE |->
      $stable(pin_q.shared_address_lines)) else $error("address moved in cycle");
   a_idle_release: assert property (@(posedge I_CLK) disable iff (I_RST)
      st_q == dmsbp_pkg::ST_IDLE && $past(st_q) == dmsbp_pkg::ST_IDLE |->
      oe_n_q && pin_q.flash_select_n) else $error("bus not released when idle");
   a_busy_reject: assert property (@(posedge I_CLK) disable iff (I_RST)
      reject |=> irq_q[dmsbp_pkg::IRQ_REJ] && st_q == dmsbp_pkg::ST_IDLE)
      else $error("busy flash accepted a program");
   a_cycle_done: assert property (@(posedge I_CLK) disable iff (I_RST)
      st_q == dmsbp_pkg::ST_HOLD |=> ##1 st_q == dmsbp_pkg::ST_IDLE && pin_q.flash_select_n)
      else $error("flash left selected after cycle");
endmodule : dmsbp_host

// *** sim/dmsbp_dev_model.sv ***
// model of the shared-bus flash and static RAM package
// assumes pins from dmsbp_host; the bench sets the busy level
`timescale 1ns/10ps
module dmsbp_dev_model (
   input  wire logic                   i_clk,
   input  wire dmsbp_pkg::dmsbp_pins_s i_pins,
   input  wire logic [7:0]             i_hdata,
   input  wire logic                   i_hoe_n,
   input  wire logic                   i_busy,
   output logic [7:0]                  o_bus,
   output logic                        o_ready_busy
);
   logic [7:0] fmem [16];
   logic [7:0] rmem [16];
   logic [7:0] flt = 8'h55;
   logic [3:0] la, idx;
   logic       lf, f_on, r_on, wr, rd;
   assign f_on = !i_pins.flash_select_n && i_pins.flash_reset_n;
   assign r_on = !i_pins.ram_select_low_n && i_pins.ram_select_high;
   assign wr = (f_on || r_on) && !i_pins.write_strobe_n;
   assign rd = (f_on || r_on) && !i_pins.out_gate_n && i_pins.write_strobe_n;
   assign idx = f_on ? {i_pins.flash_upper_address_lines[1:0], i_pins.shared_address_lines[1:0]}
                     : i_pins.shared_address_lines[3:0];
   assign o_ready_busy = !i_busy;
   // released bus shows a moving pattern, never the last value
   always @(posedge i_clk) flt <= ~flt;
   always @(posedge wr) begin
      lf <= f_on;
      la <= idx;
   end
   always @(negedge wr) begin
      if (lf) fmem[la] <= i_hdata;
      else rmem[la] <= i_hdata;
   end
   always_comb o_bus = !i_hoe_n ? i_hdata : rd ? (f_on ? fmem[idx] : rmem[idx]) : flt;
endmodule : dmsbp_dev_model

// *** sim/dmsbp_host_bench.sv ***
// self-checking bench for dmsbp_host over apb
// assumes dmsbp_dev_model on the memory bus
`timescale 1ns/10ps
module dmsbp_host_bench;
   logic        clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, busy = 0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, rd, prdata;
   logic        pready, pslverr, oe_n, irq, rb;
   logic [7:0]  hdata, bus;
   logic [19:0] wa [4] = '{20'h20001, 20'h00001, 20'h00001, 20'h00002};
   logic [19:0] ra [4] = '{20'h20001, 20'h00001, 20'h20001, 20'h00002};
   logic [7:0]  wd [4] = '{8'h5A, 8'h3C, 8'hC3, 8'hA8};
   int          error_cnt = 0, n_compared = 0;
   dmsbp_pkg::dmsbp_pins_s pins;
   always #5 clk = ~clk;
   dmsbp_host uut (.I_CLK(clk), .I_RST(rst), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr),
      .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
      .O_PRDATA(prdata), .O_PINS(pins), .O_DATA(hdata), .O_DATA_OE_N(oe_n), .I_DATA(bus),
      .I_FLASH_READY_BUSY(rb), .O_IRQ(irq));
   dmsbp_dev_model dev (.i_clk(clk), .i_pins(pins), .i_hdata(hdata), .i_hoe_n(oe_n),
      .i_busy(busy), .o_bus(bus), .o_ready_busy(rb));
   task results;
      $display("errors %0d compared %0d", error_cnt, n_compared);
      if (error_cnt == 0 && n_compared > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : results
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e) begin
         error_cnt++;
         $display("[ERR] t=%0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1;
      pen <= 0;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      psel <= 0;
      pen <= 0;
   endtask : apb
   task rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      apb(0, a, 32'h0);
      chk(rd & m, e);
      chk({31'h0, pslverr}, 32'h0);
   endtask : rdchk
   // one memory cycle; waits on the busy flag, bounded
   task cyc(input logic t, input logic w, input logic s, input logic [19:0] a,
            input logic [7:0] d);
      apb(1, dmsbp_pkg::OFS_ADDR, {12'h0, a});
      apb(1, dmsbp_pkg::OFS_WDATA, {24'h0, d});
      apb(1, dmsbp_pkg::OFS_CTRL, {27'h0, 1'b1, s, t, w, 1'b1});
      rd = 32'h1;
      for (int i = 0; i < 40 && rd[0]; i++) apb(0, dmsbp_pkg::OFS_CTRL, 32'h0);
      chk(rd[0], 1'b0);
   endtask : cyc
   always @(posedge clk) begin
      if (!rst && (!pins.flash_select_n || !pins.ram_select_low_n)) begin
         chk(!pins.flash_select_n && !pins.ram_select_low_n && pins.ram_select_high, 0);
         chk(!oe_n && !pins.out_gate_n, 0);
      end
   end
   initial begin
      #200000;
      error_cnt++;
      results();
   end
   initial begin
      repeat (16) @(posedge clk);
      rst <= 0;
      @(posedge clk);
      chk({pins.flash_select_n, pins.ram_select_low_n, pins.ram_select_high, pins.out_gate_n,
           pins.write_strobe_n, pins.flash_reset_n, oe_n, irq}, 8'hDE);
      rdchk(8'h20, 32'hFFFFFFFF, 32'h0);
      rdchk(dmsbp_pkg::OFS_TIMING, 32'hFF, 32'hA);
      apb(1, dmsbp_pkg::OFS_MASK, 32'h1);
      for (int i = 0; i < 4; i++) cyc(i == 2, 1, i > 1, wa[i], wd[i]);
      for (int i = 0; i < 4; i++) begin
         cyc(i == 2, 0, 0, ra[i], 8'h00);
         rdchk(dmsbp_pkg::OFS_RDATA, 32'hFF, {24'h0, wd[i]});
      end
      rdchk(dmsbp_pkg::OFS_STAT, 32'h3F8, 32'h2B0);
      chk(irq, 1);
      apb(1, dmsbp_pkg::OFS_IRQ, 32'h1);
      rdchk(dmsbp_pkg::OFS_IRQ, 32'h1, 32'h0);
      chk(irq, 0);
      busy <= 1;
      repeat (3) @(posedge clk);
      // bit 8 is the cycle-busy flag, idle here; only ready drops
      rdchk(dmsbp_pkg::OFS_STAT, 32'h300, 32'h000);
      cyc(0, 1, 0, 20'h00003, 8'h11);
      rdchk(dmsbp_pkg::OFS_IRQ, 32'h3, 32'h2);
      apb(1, dmsbp_pkg::OFS_IRQ, 32'h3);
      cyc(0, 1, 0, 20'h00003, 8'hB0);
      rdchk(dmsbp_pkg::OFS_IRQ, 32'h3, 32'h1);
      busy <= 0;
      repeat (3) @(posedge clk);
      rdchk(dmsbp_pkg::OFS_IRQ, 32'h4, 32'h4);
      apb(1, dmsbp_pkg::OFS_CTRL, 32'h0);
      // reset bit reaches the pin one edge after the register
      repeat (2) @(posedge clk);
      chk(pins.flash_reset_n, 0);
      // flash read with reset low ends at once and keeps the old byte
      apb(1, dmsbp_pkg::OFS_CTRL, 32'h1);
      repeat (6) @(posedge clk);
      rdchk(dmsbp_pkg::OFS_CTRL, 32'h1, 32'h0);
      rdchk(dmsbp_pkg::OFS_RDATA, 32'hFF, {24'h0, wd[3]});
      results();
   end
endmodule : dmsbp_host_bench
